// >>> design/pcmd_pkg.sv
// constants for the port command power and led control block
package pcmd_pkg;

    // register map, byte addresses on the word-wide bus
    localparam int             REG_ADDR_W   = 8;
    localparam logic [7:0]     CMD_OFFSET   = 8'h00;
    localparam logic [7:0]     CAPS_OFFSET  = 8'h04;
    localparam logic [7:0]     STAT_OFFSET  = 8'h08;

    // port_command_status field positions
    localparam int             ASP_BIT      = 27;
    localparam int             AGGRESSIVE_POWER_ENABLE_BIT     = 26;
    localparam int             LED_FOR_PACKET_DEVICE_ENABLE_BIT     = 25;
    localparam int             ATAPI_BIT    = 24;
    localparam int             AUTO_PARTIAL_TO_SLUMBER_ENABLE_BIT    = 23;
    localparam int             SWITCHING_CAPABLE_PORT_BIT    = 22;
    localparam int             ESP_BIT      = 21;
    localparam int             CPD_BIT      = 20;
    localparam int             PRESENCE_SWITCH_ATTACHED_BIT     = 19;
    localparam int             HOTPLUG_CAPABLE_PORT_BIT     = 18;

    // capability mirror field positions
    localparam int             SALP_BIT     = 0;
    localparam int             APST_BIT     = 1;
    localparam int             SPM_BIT      = 2;
    localparam int             FBSS_BIT     = 3;
    localparam int             SXS_BIT      = 4;

    // status field positions
    localparam int             P2S_WAIT_BIT = 0;
    localparam int             P2S_DONE_BIT = 1;
    localparam int             LED_BIT      = 2;

    localparam logic [31:0]    WORD_ZERO    = 32'h0000_0000;
    localparam logic           BIT_RESET    = 1'b0;

    // bus encodings
    localparam logic [1:0]     HTRANS_IDLE  = 2'b00;
    localparam logic [2:0]     HSIZE_WORD   = 3'b010;
    localparam logic           HRESP_OKAY   = 1'b0;

    // timing
    localparam int             CLK_PERIOD_NS   = 10;
    localparam int             P2S_WAIT_NS     = 10000;
    localparam int             P2S_WAIT_CYCLES = (P2S_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int             SLOT_COUNT   = 32;

    typedef enum logic [1:0] {
        P2S_IDLE,
        P2S_COUNT,
        P2S_DONE
    } p2s_state_type;

endpackage : pcmd_pkg

// >>> design/queue_drain_detect.sv
// detects the moment both outstanding-command vectors become empty
`timescale 1ns/10ps
module queue_drain_detect
    import pcmd_pkg::*;
#(
    parameter int SLOTS = SLOT_COUNT
) (
    input  wire logic             mclk_in,
    input  wire logic             arst_n_in,
    input  wire logic             ce_in,
    input  wire logic [SLOTS-1:0] issue_in,
    input  wire logic [SLOTS-1:0] tags_in,
    output logic                  drained_out
);

    logic busy_q;
    logic busy_d;

    assign busy_d = (|issue_in) || (|tags_in);

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            busy_q <= BIT_RESET;
        end else if (ce_in) begin
            busy_q <= busy_d;
        end
    end

    // one vector emptying while the other is already empty gives one pulse
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            drained_out <= BIT_RESET;
        end else if (ce_in) begin
            drained_out <= busy_q && !busy_d;
        end
    end

endmodule // queue_drain_detect

// >>> design/port_cmd_power_led.sv
// port command register power, led and capability bits behind an ahb-lite slave
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
// Contract
// - aggressive enable, select one: drain enters slumber
// - aggressive enable, select zero: drain enters partial
// - aggressive enable lets link drop power autonomously
// - led enable drives led regardless of atapi
// - led enable clear: led only for non-atapi
// - atapi bit read-write, reset zero, gates led
// - auto partial-to-slumber only while enable set
// - switching bit read-only, needs both capabilities
// - external bit read-only, implies connector capability
// - external and hotplug bits never both set
// - cold presence bit read-only, hardware initialised
// - presence switch bit read-only, hardware initialised
module port_cmd_power_led
    import pcmd_pkg::*;
#(
    parameter int   SLOTS          = SLOT_COUNT,
    parameter int   P2S_WAIT       = P2S_WAIT_CYCLES,
    parameter logic CAP_LINK_POWER = 1'b1,
    parameter logic CAP_AUTO_TRANS = 1'b1,
    parameter logic CAP_MULTIPLIER = 1'b1,
    parameter logic CAP_SWITCHING  = 1'b1,
    parameter logic CAP_EXT_CONN   = 1'b1,
    parameter logic PORT_SWITCHING = 1'b0,
    parameter logic PORT_EXTERNAL  = 1'b0,
    parameter logic PORT_HOTPLUG   = 1'b0,
    parameter logic PORT_COLD_PRES = 1'b0,
    parameter logic PORT_PRES_SW   = 1'b0
) (
    input  wire logic             mclk_in,
    input  wire logic             arst_n_in,
    input  wire logic             ce_in,
    input  wire logic             hsel_in,
    input  wire logic [31:0]      haddr_in,
    input  wire logic [1:0]       htrans_in,
    input  wire logic             hwrite_in,
    input  wire logic [2:0]       hsize_in,
    input  wire logic [31:0]      hwdata_in,
    input  wire logic             hready_in,
    output logic [31:0]           hrdata_out,
    output logic                  hreadyout_out,
    output logic                  hresp_out,
    input  wire logic [SLOTS-1:0] command_issue_in,
    input  wire logic [SLOTS-1:0] active_tags_in,
    input  wire logic             cmd_active_in,
    input  wire logic             link_partial_in,
    output logic                  partial_req_out,
    output logic                  slumber_req_out,
    output logic                  led_out
);

    localparam int CNT_W = $clog2(P2S_WAIT + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(P2S_WAIT - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // hardware-initialised bits; illegal strap combinations are masked off
    localparam logic SWITCHING_CAPABLE_PORT_VAL = PORT_SWITCHING && CAP_MULTIPLIER && CAP_SWITCHING;
    localparam logic ESP_VAL   = PORT_EXTERNAL && CAP_EXT_CONN;
    localparam logic HOTPLUG_CAPABLE_PORT_VAL  = PORT_HOTPLUG && !ESP_VAL;
    localparam logic CPD_VAL   = PORT_COLD_PRES;
    localparam logic PRESENCE_SWITCH_ATTACHED_VAL  = PORT_PRES_SW;

    logic                  asp_q;
    logic                  aggressive_power_enable_q;
    logic                  led_for_packet_device_enable_q;
    logic                  atapi_q;
    logic                  auto_partial_to_slumber_enable_q;
    logic                  wr_pend_q;
    logic                  rd_pend_q;
    logic [REG_ADDR_W-1:0] wr_addr_q;
    logic [REG_ADDR_W-1:0] rd_addr_q;
    logic                  addr_phase;
    logic                  wr_cmd;
    logic                  drained;
    p2s_state_type         p2s_state_q;
    logic [CNT_W-1:0]      p2s_cnt_q;
    logic                  p2s_fire;
    logic [31:0]           cmd_word;
    logic [31:0]           caps_word;
    logic [31:0]           stat_word;
    logic [31:0]           rd_word;

    // ---------------- bus slave ----------------
    assign addr_phase = hsel_in && hready_in && (htrans_in[1] != HTRANS_IDLE[1]);
    assign wr_cmd     = wr_pend_q && (wr_addr_q == CMD_OFFSET);

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_pend_q <= BIT_RESET;
            wr_addr_q <= '0;
        end else if (ce_in) begin
            wr_pend_q <= addr_phase && hwrite_in && (hsize_in == HSIZE_WORD);
            if (addr_phase) begin
                wr_addr_q <= haddr_in[REG_ADDR_W-1:0];
            end
        end
    end

    // reads take one wait state so a read right after a write sees the new value
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_pend_q     <= BIT_RESET;
            rd_addr_q     <= '0;
            hreadyout_out <= 1'b1;
            hrdata_out    <= WORD_ZERO;
        end else if (ce_in) begin
            if (rd_pend_q) begin
                rd_pend_q     <= BIT_RESET;
                hreadyout_out <= 1'b1;
                hrdata_out    <= rd_word;
            end else if (addr_phase && !hwrite_in) begin
                rd_pend_q     <= 1'b1;
                rd_addr_q     <= haddr_in[REG_ADDR_W-1:0];
                hreadyout_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hresp_out <= HRESP_OKAY;
        end else if (ce_in) begin
            hresp_out <= HRESP_OKAY;
        end
    end

    // ---------------- software bits ----------------
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            asp_q   <= BIT_RESET;
            aggressive_power_enable_q  <= BIT_RESET;
            led_for_packet_device_enable_q  <= BIT_RESET;
            atapi_q <= BIT_RESET;
            auto_partial_to_slumber_enable_q <= BIT_RESET;
        end else if (ce_in && wr_cmd) begin
            asp_q   <= hwdata_in[ASP_BIT] && CAP_LINK_POWER;
            aggressive_power_enable_q  <= hwdata_in[AGGRESSIVE_POWER_ENABLE_BIT] && CAP_LINK_POWER;
            led_for_packet_device_enable_q  <= hwdata_in[LED_FOR_PACKET_DEVICE_ENABLE_BIT];
            atapi_q <= hwdata_in[ATAPI_BIT];
            // masked so a careless write cannot enable an absent feature
            auto_partial_to_slumber_enable_q <= hwdata_in[AUTO_PARTIAL_TO_SLUMBER_ENABLE_BIT] && CAP_AUTO_TRANS;
        end
    end

    always_comb begin
        cmd_word            = WORD_ZERO;
        cmd_word[ASP_BIT]   = asp_q;
        cmd_word[AGGRESSIVE_POWER_ENABLE_BIT]  = aggressive_power_enable_q;
        cmd_word[LED_FOR_PACKET_DEVICE_ENABLE_BIT]  = led_for_packet_device_enable_q;
        cmd_word[ATAPI_BIT] = atapi_q;
        cmd_word[AUTO_PARTIAL_TO_SLUMBER_ENABLE_BIT] = auto_partial_to_slumber_enable_q;
        cmd_word[SWITCHING_CAPABLE_PORT_BIT] = SWITCHING_CAPABLE_PORT_VAL;
        cmd_word[ESP_BIT]   = ESP_VAL;
        cmd_word[CPD_BIT]   = CPD_VAL;
        cmd_word[PRESENCE_SWITCH_ATTACHED_BIT]  = PRESENCE_SWITCH_ATTACHED_VAL;
        cmd_word[HOTPLUG_CAPABLE_PORT_BIT]  = HOTPLUG_CAPABLE_PORT_VAL;
    end

    always_comb begin
        caps_word           = WORD_ZERO;
        caps_word[SALP_BIT] = CAP_LINK_POWER;
        caps_word[APST_BIT] = CAP_AUTO_TRANS;
        caps_word[SPM_BIT]  = CAP_MULTIPLIER;
        caps_word[FBSS_BIT] = CAP_SWITCHING;
        caps_word[SXS_BIT]  = CAP_EXT_CONN || ESP_VAL;
        stat_word               = WORD_ZERO;
        stat_word[P2S_WAIT_BIT] = (p2s_state_q == P2S_COUNT);
        stat_word[P2S_DONE_BIT] = (p2s_state_q == P2S_DONE);
        stat_word[LED_BIT]      = led_out;
    end

    // unmapped addresses read as zero and ignore writes
    always_comb begin
        unique case (rd_addr_q)
            CMD_OFFSET:  rd_word = cmd_word;
            CAPS_OFFSET: rd_word = caps_word;
            STAT_OFFSET: rd_word = stat_word;
            default:     rd_word = WORD_ZERO;
        endcase
    end

    // ---------------- aggressive power entry ----------------
    queue_drain_detect #(
        .SLOTS (SLOTS)
    ) u_drain (
        .mclk_in     (mclk_in),
        .arst_n_in   (arst_n_in),
        .ce_in       (ce_in),
        .issue_in    (command_issue_in),
        .tags_in     (active_tags_in),
        .drained_out (drained)
    );

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            partial_req_out <= BIT_RESET;
            slumber_req_out <= BIT_RESET;
        end else if (ce_in) begin
            partial_req_out <= drained && aggressive_power_enable_q && !asp_q;
            slumber_req_out <= (drained && aggressive_power_enable_q && asp_q) || p2s_fire;
        end
    end

    // ---------------- automatic partial to slumber ----------------
    assign p2s_fire = (p2s_state_q == P2S_COUNT) && auto_partial_to_slumber_enable_q && link_partial_in && (p2s_cnt_q == CNT_LAST);

    // a dropped enable or a link that left partial aborts the wait at once
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            p2s_state_q <= P2S_IDLE;
            p2s_cnt_q   <= CNT_ZERO;
        end else if (ce_in) begin
            if (!auto_partial_to_slumber_enable_q || !link_partial_in) begin
                p2s_state_q <= P2S_IDLE;
                p2s_cnt_q   <= CNT_ZERO;
            end else begin
                unique case (p2s_state_q)
                    P2S_IDLE: begin
                        p2s_state_q <= P2S_COUNT;
                        p2s_cnt_q   <= CNT_ZERO;
                    end
                    P2S_COUNT: begin
                        if (p2s_fire) begin
                            p2s_state_q <= P2S_DONE;
                        end else begin
                            p2s_cnt_q <= p2s_cnt_q + CNT_W'(1);
                        end
                    end
                    P2S_DONE: begin
                        p2s_state_q <= P2S_DONE;
                    end
                    default: begin
                        p2s_state_q <= P2S_IDLE;
                    end
                endcase
            end
        end
    end

    // ---------------- activity led ----------------
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            led_out <= BIT_RESET;
        end else if (ce_in) begin
            led_out <= cmd_active_in && (led_for_packet_device_enable_q || !atapi_q);
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!arst_n_in);

    agg_slumber_a: assert property (ce_in && drained && aggressive_power_enable_q && asp_q |=> slumber_req_out)
        else $error("drain with slumber select did not request slumber");

    agg_partial_a: assert property (ce_in && drained && aggressive_power_enable_q && !asp_q |=> partial_req_out && !slumber_req_out)
        else $error("drain with partial select did not request partial");

    agg_disabled_a: assert property (ce_in && !aggressive_power_enable_q |=> !partial_req_out)
        else $error("partial requested with aggressive mode off");

    led_forced_a: assert property (ce_in && cmd_active_in && led_for_packet_device_enable_q |=> led_out)
        else $error("led not driven with packet led enable set");

    led_atapi_a: assert property (ce_in && !led_for_packet_device_enable_q && atapi_q |=> !led_out)
        else $error("led driven for packet device");

    atapi_write_a: assert property (ce_in && wr_cmd |=> atapi_q == $past(hwdata_in[ATAPI_BIT]))
        else $error("packet device bit did not take written value");

    p2s_off_a: assert property (ce_in && !auto_partial_to_slumber_enable_q |=> p2s_state_q == P2S_IDLE)
        else $error("partial to slumber wait runs while disabled");

    p2s_wait_a: assert property ($rose(p2s_state_q == P2S_COUNT) && ce_in
                                 |-> !slumber_req_out ##1 !slumber_req_out)
        else $error("slumber requested before the partial wait elapsed");

    switch_strap_a: assert property (cmd_word[SWITCHING_CAPABLE_PORT_BIT] |-> CAP_MULTIPLIER && CAP_SWITCHING)
        else $error("switching bit set without both capabilities");

    ext_conn_a: assert property (cmd_word[ESP_BIT] |-> caps_word[SXS_BIT])
        else $error("external bit set without connector capability");

    ext_hotplug_a: assert property (!(cmd_word[ESP_BIT] && cmd_word[HOTPLUG_CAPABLE_PORT_BIT]))
        else $error("external and hotplug bits both set");

    no_power_cap_a: assert property (!CAP_LINK_POWER && ce_in && wr_cmd |=> !aggressive_power_enable_q && !asp_q)
        else $error("aggressive bits writable without power capability");

    pulse_single_a: assert property (ce_in && partial_req_out |=> !partial_req_out)
        else $error("partial request held longer than one cycle");

    led_plain_a: assert property (ce_in && cmd_active_in && !atapi_q |=> led_out)
        else $error("led not driven for a non-packet device");

    atapi_hold_a: assert property (ce_in && !wr_cmd |=> $stable(atapi_q))
        else $error("packet device bit changed without a write");

    freeze_led_a: assert property (!ce_in |=> $stable(led_out))
        else $error("led changed while the clock enable was low");

endmodule // port_cmd_power_led

// >>> sim/sata_link_model.sv
// far-side link model: enters partial on request, leaves on slumber or wake
`timescale 1ns/10ps
module sata_link_model (
    input  wire logic mclk_in,
    input  wire logic arst_n_in,
    input  wire logic partial_req_in,
    input  wire logic slumber_req_in,
    input  wire logic wake_in,
    input  wire logic slow_in,
    output logic      link_partial_out
);
    logic pend_q;

    // slow mode answers a partial request one cycle late
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= partial_req_in;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            link_partial_out <= 1'b0;
        end else if (slumber_req_in || wake_in) begin
            link_partial_out <= 1'b0;
        end else if (slow_in ? pend_q : partial_req_in) begin
            link_partial_out <= 1'b1;
        end
    end
endmodule // sata_link_model

// >>> sim/port_cmd_power_led_test.sv
// self-checking bench for the port command power and led block
`timescale 1ns/10ps
module port_cmd_power_led_test;
    import pcmd_pkg::*;
    localparam int WAIT_N = 4;
    logic        clk, rst_n, hsel, hwrite, hready, hresp, ca, lp, p_req, s_req, led, wake, slow, ce;
    logic [31:0] haddr, hwdata, hrdata, issue, tags, w, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          seed, n_fail, total_checks, n_p, n_s, cycles;

    port_cmd_power_led #(
        .P2S_WAIT       (WAIT_N),
        .CAP_MULTIPLIER (1'b0),
        .PORT_SWITCHING (1'b1),
        .PORT_EXTERNAL  (1'b1),
        .PORT_HOTPLUG   (1'b1),
        .PORT_COLD_PRES (1'b1)
    ) port_cmd_power_led_i (
        .mclk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .command_issue_in(issue), .active_tags_in(tags), .cmd_active_in(ca),
        .link_partial_in(lp), .partial_req_out(p_req), .slumber_req_out(s_req), .led_out(led)
    );

    sata_link_model sata_link_model_i (
        .mclk_in(clk), .arst_n_in(rst_n), .partial_req_in(p_req), .slumber_req_in(s_req),
        .wake_in(wake), .slow_in(slow), .link_partial_out(lp)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // hardwired bits: external and cold presence; switching lacks multiplier cap
    function automatic logic [31:0] exp_cmd(input logic [31:0] wv);
        logic [31:0] ro;
        ro = 32'h0000_0000;
        ro[ESP_BIT] = 1'b1;
        ro[CPD_BIT] = 1'b1;
        return (wv & 32'h0F80_0000) | ro;
    endfunction

    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        chk({31'h0000_0000, hresp}, {31'h0000_0000, HRESP_OKAY});
    endtask

    task automatic drain(input logic [31:0] wv, input int ep, input int es);
        bus(CMD_OFFSET, 1'b1, wv);
        n_p = 0;
        n_s = 0;
        if ($random(seed) & 1) begin
            issue <= $random(seed) | 32'h0000_0001;
        end else begin
            tags <= $random(seed) | 32'h0000_0001;
        end
        repeat (3) @(posedge clk);
        issue <= 32'h0000_0000;
        tags <= 32'h0000_0000;
        repeat (WAIT_N + 16) @(posedge clk);
        chk(n_p, ep);
        chk(n_s, es);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
    endtask

    always @(posedge clk) begin
        if (p_req === 1'b1) n_p++;
        if (s_req === 1'b1) n_s++;
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        seed = 69720;
        {hsel, hwrite, ca, wake, slow} = 5'b0_0000;
        ce = 1'b1;
        {haddr, hwdata, issue, tags} = {4{32'h0000_0000}};
        htrans = HTRANS_IDLE;
        hsize = HSIZE_WORD;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(CMD_OFFSET, 1'b0, 32'h0000_0000);
        chk(rd, exp_cmd(32'h0000_0000));
        bus(CAPS_OFFSET, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_001B);
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            w[AGGRESSIVE_POWER_ENABLE_BIT] = 1'b0;
            bus(CMD_OFFSET, 1'b1, w);
            bus(CMD_OFFSET, 1'b0, 32'h0000_0000);
            chk(rd, exp_cmd(w));
        end
        // unmapped place: writes dropped, reads zero
        bus(8'h0C, 1'b1, 32'hFFFF_FFFF);
        bus(8'h0C, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            w = 32'h0000_0000;
            w[LED_FOR_PACKET_DEVICE_ENABLE_BIT] = i[1];
            w[ATAPI_BIT] = i[0];
            bus(CMD_OFFSET, 1'b1, w);
            for (int j = 0; j < 6; j++) begin
                ca <= (j < 2) ? 1'b1 : 1'($random(seed));
                @(posedge clk);
                @(posedge clk);
                chk({31'h0000_0000, led}, {31'h0000_0000, ca & (i[1] | ~i[0])});
            end
        end
        // enable low must freeze the led even with its source gone
        ca <= 1'b1;
        repeat (2) @(posedge clk);
        ce <= 1'b0;
        ca <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0000_0000, led}, 32'h0000_0001);
        ce <= 1'b1;
        repeat (2) @(posedge clk);
        chk({31'h0000_0000, led}, 32'h0000_0000);
        // mid-run reset clears the packet device and led enable bits
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(CMD_OFFSET, 1'b0, 32'h0000_0000);
        chk(rd, exp_cmd(32'h0000_0000));
        // both capabilities present, so software may set the power bits
        drain(32'h0400_0000, 1, 0);
        drain(32'h0C00_0000, 0, 1);
        drain(32'h0800_0000, 0, 0);
        drain(32'h0480_0000, 1, 1);
        slow <= 1'b1;
        drain(32'h0480_0000, 1, 1);
        drain(32'h0400_0000, 1, 0);
        summarize();
    end
endmodule // port_cmd_power_led_test
